// File: design/uoif_flags.sv
// Global interrupt flag register (upper half) and core soft reset.
// Assumes event inputs are one-cycle pulses and level inputs are
// synchronous to CLK_I; the bus master follows AXI4-Lite.
//
// Contract
// - Core soft reset clears bus-side and link-side state and most registers; here it only resets the flags and ID change tracking.
// - Flag register at offset 0x014, reset value 0x0400_0021.
// - Bit 31 sets on resume (device) or remote wakeup (host).
// - Bit 30 sets on session request (A-device) or VBUS valid (B-device).
// - Bit 29 sets on peripheral disconnect, host mode only.
// - Bit 28 sets whenever the sensed ID state changes.
// - Bit 26 shows periodic FIFO half or fully empty, host mode.
// - Bit 25 follows any host channel flag, clears when all clear.
// - Bit 24 follows port change flags, clears when they clear.
// - Bit 21 sets at frame end with periodic work unfinished, host.
// - Bit 21 sets at frame end with iso OUT unfinished, device.
// - Bit 20 sets at frame end with iso IN unfinished, device.
// - Bit 19 follows any OUT endpoint flag, clears when all clear.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module uoif_flags #(
  parameter int NUM_CHANNELS  = 8,
  parameter int NUM_OUT_EPS   = 4
) (
  input  wire logic                    CLK_I,
  input  wire logic                    SRST_I,
  // AXI4-Lite slave
  input  wire logic [11:0]             AWADDR_I,
  input  wire logic                    AWVALID_I,
  output logic                         AWREADY_O,
  input  wire logic [31:0]             WDATA_I,
  input  wire logic [3:0]              WSTRB_I,
  input  wire logic                    WVALID_I,
  output logic                         WREADY_O,
  output logic [1:0]                   BRESP_O,
  output logic                         BVALID_O,
  input  wire logic                    BREADY_I,
  input  wire logic [11:0]             ARADDR_I,
  input  wire logic                    ARVALID_I,
  output logic                         ARREADY_O,
  output logic [31:0]                  RDATA_O,
  output logic [1:0]                   RRESP_O,
  output logic                         RVALID_O,
  input  wire logic                    RREADY_I,
  // Event and status sources
  input  wire logic                    RESUME_DETECT_I,
  input  wire logic                    REMOTE_WAKEUP_I,
  input  wire logic                    SESSION_REQUEST_I,
  input  wire logic                    VBUS_VALID_I,
  input  wire logic                    DISCONNECT_I,
  input  wire logic                    ID_STATE_I,
  input  wire logic                    PTXFIFO_HALF_EMPTY_I,
  input  wire logic                    PTXFIFO_EMPTY_I,
  input  wire logic [NUM_CHANNELS-1:0] CHANNEL_FLAGS_I,
  input  wire logic                    PORT_FLAGS_I,
  input  wire logic                    FRAME_END_I,
  input  wire logic                    PERIODIC_PENDING_I,
  input  wire logic                    ISO_OUT_PENDING_I,
  input  wire logic                    ISO_IN_PENDING_I,
  input  wire logic [NUM_OUT_EPS-1:0]  OUT_EP_FLAGS_I,
  // Outputs
  output logic                         CORE_SOFT_RESET_O,
  output logic                         DEVICE_MODE_O
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] flags;
    logic [2:0]  config_bits;
    logic        id_last;
    logic        id_seen;
    logic [3:0]  reset_count;
    logic        core_reset;
  } uoif_state_t;

  uoif_state_t state;
  uoif_state_t next_state;

  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    logic [31:0] mask;
    mask = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      mask[i*8 +: 8] = {8{strb[i]}};
    end
    return mask;
  endfunction

  logic        device_mode;
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] clear_bits;
  logic        channel_any;
  logic        out_ep_any;
  logic        ptx_level;

  assign device_mode = state.config_bits[uoif_pkg::DEVICE_MODE_BIT];
  assign channel_any = |CHANNEL_FLAGS_I;
  assign out_ep_any  = |OUT_EP_FLAGS_I;
  assign ptx_level   = state.config_bits[uoif_pkg::PERIODIC_TXFIFO_THRESHOLD_BIT] ?
                       PTXFIFO_EMPTY_I : PTXFIFO_HALF_EMPTY_I;
  assign wr_fire = state.aw_held && state.w_held && !state.bvalid;
  assign rd_fire = ARVALID_I && !state.rvalid;

  always_comb begin
    next_state = state;
    clear_bits = 32'h0000_0000;

    // --------------------------------------------------------------------
    // Write channel capture, either order
    // --------------------------------------------------------------------
    if (AWVALID_I && !state.aw_held) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = AWADDR_I;
    end
    if (WVALID_I && !state.w_held) begin
      next_state.w_held = 1'b1;
      next_state.w_data = WDATA_I;
      next_state.w_strb = WSTRB_I;
    end
    if (state.bvalid && BREADY_I) begin
      next_state.bvalid = 1'b0;
    end

    if (wr_fire) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = uoif_pkg::RESP_OKAY;
      case (state.aw_addr)
        uoif_pkg::RESET_CTL_OFFSET: begin
          if (state.w_strb[0] && state.w_data[uoif_pkg::CORE_RESET_BIT]) begin
            next_state.reset_count = 4'(uoif_pkg::SOFT_RESET_CYC);
          end
        end
        uoif_pkg::FLAGS_OFFSET: begin
          // Reserved bits are not stored, so a stray write cannot
          // disturb them
          clear_bits = state.w_data & strobe_mask(state.w_strb)
                       & uoif_pkg::W1C_MASK;
        end
        uoif_pkg::CONFIG_OFFSET: begin
          if (state.w_strb[0]) begin
            next_state.config_bits = state.w_data[2:0];
          end
        end
        uoif_pkg::SOURCES_OFFSET: ;
        default: next_state.bresp = uoif_pkg::RESP_SLVERR;
      endcase
    end

    // --------------------------------------------------------------------
    // Read channel
    // --------------------------------------------------------------------
    if (state.rvalid && RREADY_I) begin
      next_state.rvalid = 1'b0;
    end
    if (rd_fire) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = uoif_pkg::RESP_OKAY;
      case (ARADDR_I)
        uoif_pkg::RESET_CTL_OFFSET:
          next_state.rdata = {31'h0000_0000, state.core_reset};
        uoif_pkg::FLAGS_OFFSET: next_state.rdata = state.flags;
        uoif_pkg::CONFIG_OFFSET:
          next_state.rdata = {29'h0000_0000, state.config_bits};
        uoif_pkg::SOURCES_OFFSET:
          next_state.rdata = {30'h0000_0000, state.id_last, ptx_level};
        default: begin
          next_state.rdata = 32'h0000_0000;
          next_state.rresp = uoif_pkg::RESP_SLVERR;
        end
      endcase
    end

    // --------------------------------------------------------------------
    // Sticky flags: clear first, so a same-cycle event wins
    // --------------------------------------------------------------------
    next_state.flags = state.flags & ~clear_bits;
    if (device_mode ? RESUME_DETECT_I : REMOTE_WAKEUP_I) begin
      next_state.flags[uoif_pkg::WAKEUP_BIT] = 1'b1;
    end
    if (state.config_bits[uoif_pkg::A_DEVICE_BIT] ? SESSION_REQUEST_I
                                                  : VBUS_VALID_I) begin
      next_state.flags[uoif_pkg::SESSION_BIT] = 1'b1;
    end
    if (!device_mode && DISCONNECT_I) begin
      next_state.flags[uoif_pkg::DISCONN_BIT] = 1'b1;
    end
    next_state.id_last = ID_STATE_I;
    next_state.id_seen = 1'b1;
    if (state.id_seen && ID_STATE_I != state.id_last) begin
      next_state.flags[uoif_pkg::ID_CHANGE_BIT] = 1'b1;
    end
    if (FRAME_END_I) begin
      if (device_mode ? ISO_OUT_PENDING_I : PERIODIC_PENDING_I) begin
        next_state.flags[uoif_pkg::PINC_BIT] = 1'b1;
      end
      if (device_mode && ISO_IN_PENDING_I) begin
        next_state.flags[uoif_pkg::ISOIN_BIT] = 1'b1;
      end
    end

    // Aggregate flags track their sources and ignore writes
    next_state.flags[uoif_pkg::PTXFE_BIT] = !device_mode && ptx_level;
    next_state.flags[uoif_pkg::HCHAN_BIT] = !device_mode && channel_any;
    next_state.flags[uoif_pkg::HPORT_BIT] = !device_mode && PORT_FLAGS_I;
    next_state.flags[uoif_pkg::OUTEP_BIT] = device_mode && out_ep_any;
    // Bits 18:0 are held at their reset pattern in this block
    next_state.flags[18:0] = uoif_pkg::FLAGS_RESET[18:0];
    next_state.flags[27]   = 1'b0;
    next_state.flags[23:22] = 2'h0;

    // --------------------------------------------------------------------
    // Core soft reset: flags return to reset values and ID change tracking restarts
    // --------------------------------------------------------------------
    if (state.reset_count != 4'h0) begin
      next_state.reset_count = state.reset_count - 4'h1;
    end
    next_state.core_reset = (next_state.reset_count != 4'h0);
    if (state.core_reset) begin
      next_state.flags   = uoif_pkg::FLAGS_RESET;
      next_state.id_seen = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      state             <= '0;
      state.flags       <= uoif_pkg::FLAGS_RESET;
      state.config_bits <= uoif_pkg::CONFIG_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign AWREADY_O         = !state.aw_held;
  assign WREADY_O          = !state.w_held;
  assign BVALID_O          = state.bvalid;
  assign BRESP_O           = state.bresp;
  assign ARREADY_O         = !state.rvalid;
  assign RVALID_O          = state.rvalid;
  assign RDATA_O           = state.rdata;
  assign RRESP_O           = state.rresp;
  assign CORE_SOFT_RESET_O = state.core_reset;
  assign DEVICE_MODE_O     = device_mode;

endmodule

// File: include/uoif_pkg.sv
// Package for the global interrupt flag block: offsets, bit positions,
// reset values and cycle counts. Assumes a 32-bit AXI4-Lite register bus.
package uoif_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] RESET_CTL_OFFSET = 12'h010;
  localparam logic [11:0] FLAGS_OFFSET     = 12'h014;
  localparam logic [11:0] CONFIG_OFFSET    = 12'h018;
  localparam logic [11:0] SOURCES_OFFSET   = 12'h01C;

  // ----------------------------------------------------------------------
  // Flag positions
  // ----------------------------------------------------------------------
  localparam int WAKEUP_BIT    = 31;
  localparam int SESSION_BIT   = 30;
  localparam int DISCONN_BIT   = 29;
  localparam int ID_CHANGE_BIT = 28;
  localparam int PTXFE_BIT     = 26;
  localparam int HCHAN_BIT     = 25;
  localparam int HPORT_BIT     = 24;
  localparam int PINC_BIT      = 21;
  localparam int ISOIN_BIT     = 20;
  localparam int OUTEP_BIT     = 19;

  // Config and reset control register fields
  localparam int DEVICE_MODE_BIT = 0;
  localparam int PERIODIC_TXFIFO_THRESHOLD_BIT      = 1;
  localparam int A_DEVICE_BIT    = 2;
  localparam int CORE_RESET_BIT  = 0;

  // ----------------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------------
  localparam logic [31:0] FLAGS_RESET   = 32'h0400_0021;
  localparam logic [31:0] W1C_MASK      = 32'hF030_0000;
  localparam logic [31:0] RESERVED_MASK = 32'h08C0_0000;
  localparam logic [2:0]  CONFIG_RESET  = 3'h0;

  // Soft reset pulse: time in ns and derived cycle count at 100 MHz
  localparam int CLK_MHZ         = 100;
  localparam int SOFT_RESET_NS   = 50;
  localparam int SOFT_RESET_CYC  = (SOFT_RESET_NS * CLK_MHZ + 999) / 1000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: tb/test_usb_otg_global_interrupt_flags.sv
// Bench for uoif_flags: events, aggregates, soft reset over AXI4-Lite.
// Assumes the checker and cable model are compiled before this file.
`timescale 1ns/1ns
module test_usb_otg_global_interrupt_flags;
  logic clk = 0, srst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd_d, rdo, dir = 0;
  logic [1:0] rsp, br, rr;
  logic [6:0] req = 0;
  logic [5:0] pls;
  logic [2:0] cfg = 0;
  logic idl, awr, wrd, bv, arr, rv, csr, dm;
  logic fh = 1, fe = 1, pp = 0, iop = 0, iip = 0, pf = 0;
  logic [7:0] chf = 0;
  logic [3:0] oef = 0;
  int miscompares = 0, compares = 0;
  int ev_b[9] = '{0, 1, 2, 3, 4, 6, 5, 5, 5};
  int ev_c[9] = '{1, 0, 4, 0, 0, 0, 0, 1, 1};
  int ev_f[9] = '{31, 31, 30, 30, 29, 28, 21, 21, 20};
  int ev_p[9] = '{0, 0, 0, 0, 0, 0, 4, 2, 1};
  always #5 clk = ~clk;
  uoif_cable_model cable (.clk_i(clk), .srst_i(srst), .req_i(req),
    .pulse_o(pls), .id_o(idl));
  uoif_flags #(.NUM_CHANNELS(8), .NUM_OUT_EPS(4)) uut (
    .CLK_I(clk), .SRST_I(srst), .AWADDR_I(awa), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hF), .WVALID_I(wv),
    .WREADY_O(wrd), .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bry),
    .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdo),
    .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rry),
    .RESUME_DETECT_I(pls[0]), .REMOTE_WAKEUP_I(pls[1]),
    .SESSION_REQUEST_I(pls[2]), .VBUS_VALID_I(pls[3]),
    .DISCONNECT_I(pls[4]), .ID_STATE_I(idl), .PTXFIFO_HALF_EMPTY_I(fh),
    .PTXFIFO_EMPTY_I(fe), .CHANNEL_FLAGS_I(chf), .PORT_FLAGS_I(pf),
    .FRAME_END_I(pls[5]), .PERIODIC_PENDING_I(pp),
    .ISO_OUT_PENDING_I(iop), .ISO_IN_PENDING_I(iip),
    .OUT_EP_FLAGS_I(oef), .CORE_SOFT_RESET_O(csr), .DEVICE_MODE_O(dm));
  task report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task chk_resp(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t resp %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is looked at mid-cycle so the handshake edge is never raced
  task wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, hb;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1; n = 0;
    do begin
      @(negedge clk);
      ha = awr & awv; hw = wrd & wv; hb = bv; rsp = br;
      @(posedge clk);
      if (ha) awv <= 0;
      if (hw) wv <= 0;
      n++;
    end while (!hb && n < 64);
    bry <= 0;
    if (!hb) miscompares++;
  endtask
  task rd(input logic [11:0] a);
    int n;
    logic ha, hr;
    @(posedge clk);
    ara <= a; arv <= 1; rry <= 1; n = 0;
    do begin
      @(negedge clk);
      ha = arr & arv; hr = rv; rd_d = rdo; rsp = rr;
      @(posedge clk);
      if (ha) arv <= 0;
      n++;
    end while (!hr && n < 64);
    rry <= 0;
    if (!hr) miscompares++;
  endtask
  task pulse(input int b);
    @(posedge clk); req <= 7'(1 << b);
    @(posedge clk); req <= 7'h00;
    repeat (2) @(posedge clk);
  endtask
  function logic [31:0] model();
    logic [31:0] v;
    v = dir | 32'h21;
    v[26] = !cfg[0] && (cfg[1] ? fe : fh);
    v[25] = !cfg[0] && |chf;
    v[24] = !cfg[0] && pf;
    v[19] = cfg[0] && |oef;
    return v;
  endfunction
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    int n;
    void'($urandom(52));
    repeat (12) @(posedge clk);
    srst <= 0;
    rd(12'h014); chk(rd_d, 32'h0400_0021);
    rd(12'h100); chk(rd_d, 32'h0); chk_resp(rsp, 2'h2);
    wr(12'h100, 32'h0); chk_resp(rsp, 2'h2);
    for (int i = 0; i < 9; i++) begin
      cfg = 3'(ev_c[i]); wr(12'h018, 32'(cfg));
      {pp, iop, iip} <= 3'(ev_p[i]);
      pulse(ev_b[i]);
      {pp, iop, iip} <= 3'h0;
      dir[ev_f[i]] = 1'b1;
      rd(12'h014); chk(rd_d, model());
      chk(rd_d, model());
      wr(12'h014, 32'h0); chk_resp(rsp, 2'h0);
      rd(12'h014); chk(rd_d, model());
      wr(12'h014, (32'h1 << ev_f[i]) | 32'h0708_0000);
      dir[ev_f[i]] = 1'b0;
      rd(12'h014); chk(rd_d, model());
    end
    for (int i = 0; i < 8; i++) begin
      cfg = 3'($urandom & 3); wr(12'h018, 32'(cfg));
      {chf, oef, pf, fh, fe} <= 15'($urandom);
      wr(12'h014, 32'h0708_0000);
      rd(12'h014); chk(rd_d, model());
      chk(32'(dm), 32'(cfg[0]));
      rd(12'h01C); chk(rd_d, {30'h0, idl, cfg[1] ? fe : fh});
    end
    cfg = 3'h0; wr(12'h018, 32'h0);
    pulse(1);
    wr(12'h010, 32'h1);
    n = 0;
    repeat (2) @(posedge clk);
    while (csr !== 1'b0 && n < 50) begin @(posedge clk); n++; end
    if (n >= 50) miscompares++;
    repeat (3) @(posedge clk);
    rd(12'h014); chk(rd_d, model());
    report_and_stop();
  end
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
endmodule
bind uoif_flags uoif_flags_assertions #(.NUM_CHANNELS(NUM_CHANNELS),
  .NUM_OUT_EPS(NUM_OUT_EPS)) u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I),
  .WREADY_O(WREADY_O), .BVALID_O(BVALID_O), .ARADDR_I(ARADDR_I),
  .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
  .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .CHANNEL_FLAGS_I(CHANNEL_FLAGS_I),
  .PORT_FLAGS_I(PORT_FLAGS_I), .OUT_EP_FLAGS_I(OUT_EP_FLAGS_I),
  .CORE_SOFT_RESET_O(CORE_SOFT_RESET_O), .DEVICE_MODE_O(DEVICE_MODE_O));

// File: tb/uoif_cable_model.sv
// Far-side cable model: turns bench requests into one-cycle line events.
// Assumes requests are raised for one cycle, changed after the edge.
`timescale 1ns/1ns
module uoif_cable_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic [6:0] req_i,
  output logic      [5:0] pulse_o,
  output logic            id_o
);
  // ID level persists; only a plug change request flips it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pulse_o <= 6'h00;
      id_o    <= 1'b0;
    end else begin
      pulse_o <= req_i[5:0];
      id_o    <= id_o ^ req_i[6];
    end
  end
endmodule

// File: tb/uoif_flags_assertions.sv
// Checker for the flag block: bus answers, flag views, soft reset.
// Assumes it is bound to uoif_flags and sees only its ports.
`timescale 1ns/1ns
module uoif_flags_assertions #(
  parameter int NUM_CHANNELS = 8,
  parameter int NUM_OUT_EPS  = 4
) (
  input wire logic                    CLK_I,
  input wire logic                    SRST_I,
  input wire logic                    AWVALID_I,
  input wire logic                    AWREADY_O,
  input wire logic                    WVALID_I,
  input wire logic                    WREADY_O,
  input wire logic                    BVALID_O,
  input wire logic [11:0]             ARADDR_I,
  input wire logic                    ARVALID_I,
  input wire logic                    ARREADY_O,
  input wire logic [31:0]             RDATA_O,
  input wire logic [1:0]              RRESP_O,
  input wire logic                    RVALID_O,
  input wire logic [NUM_CHANNELS-1:0] CHANNEL_FLAGS_I,
  input wire logic                    PORT_FLAGS_I,
  input wire logic [NUM_OUT_EPS-1:0]  OUT_EP_FLAGS_I,
  input wire logic                    CORE_SOFT_RESET_O,
  input wire logic                    DEVICE_MODE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  logic ar_t;
  logic ar_f;
  logic settled;
  assign ar_t = ARVALID_I && ARREADY_O;
  assign ar_f = ar_t && ARADDR_I == uoif_pkg::FLAGS_OFFSET && settled;
  // Views are only exact once no reset of either kind was seen last cycle
  always_ff @(posedge CLK_I) begin
    settled <= !SRST_I && !CORE_SOFT_RESET_O;
  end
  property p_idle; $fell(SRST_I) |-> AWREADY_O && WREADY_O && ARREADY_O
    && !BVALID_O && !RVALID_O; endproperty
  a_idle: assert property (p_idle) else $error("bus not idle");
  property p_rlat; ar_t |=> RVALID_O; endproperty
  a_rlat: assert property (p_rlat) else $error("read late");
  property p_unmap; ar_t && !(ARADDR_I inside {12'h010, 12'h014, 12'h018,
    12'h01C}) |=> RRESP_O == 2'h2 && RDATA_O == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("bad unmapped");
  property p_wlat; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O
    |-> ##[1:2] BVALID_O; endproperty
  a_wlat: assert property (p_wlat) else $error("write late");
  property p_resv; ar_f |=> RDATA_O[27] == 1'b0 && RDATA_O[23:22] == 2'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_hch; ar_f && !CORE_SOFT_RESET_O && $stable(CHANNEL_FLAGS_I)
    && $stable(DEVICE_MODE_O)
    |=> RDATA_O[25] == (!$past(DEVICE_MODE_O) && |$past(CHANNEL_FLAGS_I));
  endproperty
  a_hch: assert property (p_hch) else $error("channel flag");
  property p_hpt; ar_f && !CORE_SOFT_RESET_O && $stable(PORT_FLAGS_I)
    && $stable(DEVICE_MODE_O)
    |=> RDATA_O[24] == (!$past(DEVICE_MODE_O) && $past(PORT_FLAGS_I));
  endproperty
  a_hpt: assert property (p_hpt) else $error("port flag");
  property p_oep; ar_f && !CORE_SOFT_RESET_O && $stable(OUT_EP_FLAGS_I)
    && $stable(DEVICE_MODE_O)
    |=> RDATA_O[19] == ($past(DEVICE_MODE_O) && |$past(OUT_EP_FLAGS_I));
  endproperty
  a_oep: assert property (p_oep) else $error("endpoint flag");
  property p_soft; $rose(CORE_SOFT_RESET_O) |-> CORE_SOFT_RESET_O[*4]
    ##[1:4] !CORE_SOFT_RESET_O; endproperty
  a_soft: assert property (p_soft) else $error("soft reset span");
  c_soft: cover property ($rose(CORE_SOFT_RESET_O));
  c_dev: cover property (ar_f && DEVICE_MODE_O);
  c_hch: cover property (ar_f && |CHANNEL_FLAGS_I);
endmodule
